// ---- phy_mgmt_ctrl.sv ----
// management control pins: collision, serial management port, shared irq/power-down pin,
// reset pin filter, and an AXI4-Lite register slave
// assumes pins are asynchronous to i_clk; the management clock is sampled, not used as a clock
`timescale 1ns/1ps
module phy_mgmt_ctrl
  import phy_mgmt_pkg::*;
(
  input  wire logic        i_clk,         // system clock, 20 MHz
  input  wire logic        i_nrst,        // async reset, active low
  // axi4-lite slave
  input  wire logic [3:0]  i_awaddr,      // write address
  input  wire logic        i_awvalid,     // write address valid
  output logic             o_awready,     // write address ready
  input  wire logic [31:0] i_wdata,       // write data
  input  wire logic [3:0]  i_wstrb,       // write byte strobes
  input  wire logic        i_wvalid,      // write data valid
  output logic             o_wready,      // write data ready
  output logic [1:0]       o_bresp,       // write response
  output logic             o_bvalid,      // write response valid
  input  wire logic        i_bready,      // write response ready
  input  wire logic [3:0]  i_araddr,      // read address
  input  wire logic        i_arvalid,     // read address valid
  output logic             o_arready,     // read address ready
  output logic [31:0]      o_rdata,       // read data
  output logic [1:0]       o_rresp,       // read response
  output logic             o_rvalid,      // read data valid
  input  wire logic        i_rready,      // read data ready
  // media activity from the core
  input  wire logic        i_tx_active,   // transmit medium non-idle
  input  wire logic        i_rx_active,   // receive medium non-idle
  output logic             o_col,         // collision pin
  // serial management pins
  input  wire logic        i_mdc,         // management clock pin
  input  wire logic        i_mdio,        // management data pin level
  output logic             o_mdio,        // management data out
  output logic             o_mdio_oe,     // management data drive enable
  // shared interrupt / power-down pin, open drain
  input  wire logic        i_irq_or_powerdown_pin, // pin level
  output logic             o_irq_or_powerdown_pin, // pin out value, always low
  output logic             o_irq_or_powerdown_oe,  // high while sinking the pin
  // reset pin and results
  input  wire logic        i_rst_pin_n,   // reset pin, active low
  output logic             o_core_rst,    // core reset in progress
  output logic             o_power_down,  // power-down mode
  output logic             o_irq          // level interrupt
);

  // pin synchronisers
  logic [3:0] pins_s;
  logic       mdc_s;
  logic       mdio_s;
  logic       pd_pin_s;
  logic       rst_pin_s;
  logic       rst_req;

  phy_sync2 #(
    .W (4)
  ) u_sync (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_async ({i_mdc, i_mdio, ~i_irq_or_powerdown_pin, ~i_rst_pin_n}),
    .o_sync  (pins_s)
  );

  assign mdc_s     = pins_s[3];
  assign mdio_s    = pins_s[2];
  assign pd_pin_s  = ~pins_s[1];  // idle high, so no false low after reset
  assign rst_pin_s = ~pins_s[0];

  phy_rst_filter u_rst (
    .i_clk     (i_clk),
    .i_nrst    (i_nrst),
    .i_pin_n   (rst_pin_s),
    .o_rst_req (rst_req)
  );

  // registers
  ctrl_t       ctrl_q;
  logic [31:0] status_q;
  logic [31:0] mask_q;
  logic [EV_W-1:0] ev;

  // axi write side
  logic        aw_hold_q;
  logic        w_hold_q;
  logic [3:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        wr_fire;
  logic [31:0] wmask;
  logic        axi_wr_ctrl;
  logic        axi_wr_stat;
  logic        axi_wr_mask;

  // management engine
  mdio_state_t ms_q;
  logic [5:0]  mcnt_q;
  logic [11:0] hdr_q;
  logic [15:0] mdat_q;
  logic        mrd_q;
  logic        mdc_prev_q;
  logic        mdc_rise;
  logic [11:0] hdr_d;
  logic        mwr_q;
  logic [1:0]  mwr_idx_q;
  logic [15:0] mwr_dat_q;
  logic        m_done_q;
  logic [15:0] mrd_val;

  // misc state
  logic        col_d;
  logic        pd_d;
  logic        busy;

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[8*b +: 8] = {8{wstrb_q[b]}};
    end
  end

  assign wr_fire     = aw_hold_q && w_hold_q && !o_bvalid;
  assign axi_wr_ctrl = wr_fire && (awaddr_q == OFS_CTRL);
  assign axi_wr_stat = wr_fire && (awaddr_q == OFS_STATUS);
  assign axi_wr_mask = wr_fire && (awaddr_q == OFS_MASK);

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      aw_hold_q <= 1'b0;
      awaddr_q  <= '0;
      o_awready <= 1'b1;
    end else if (i_awvalid && o_awready) begin
      aw_hold_q <= 1'b1;
      awaddr_q  <= i_awaddr;
      o_awready <= 1'b0;
    end else if (wr_fire) begin
      aw_hold_q <= 1'b0;
      o_awready <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      w_hold_q <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
      o_wready <= 1'b1;
    end else if (i_wvalid && o_wready) begin
      w_hold_q <= 1'b1;
      wdata_q  <= i_wdata;
      wstrb_q  <= i_wstrb;
      o_wready <= 1'b0;
    end else if (wr_fire) begin
      w_hold_q <= 1'b0;
      o_wready <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_bvalid <= 1'b0;
      o_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      o_bvalid <= 1'b1;
      if (awaddr_q == OFS_CTRL || awaddr_q == OFS_STATUS || awaddr_q == OFS_MASK) begin
        o_bresp <= RESP_OKAY;
      end else begin
        o_bresp <= RESP_SLVERR;
      end
    end else if (o_bvalid && i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // axi read side
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= '0;
      o_rresp   <= RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b1;
      o_rresp   <= RESP_OKAY;
      if (i_araddr == OFS_CTRL) begin
        o_rdata <= ctrl_q;
      end else if (i_araddr == OFS_STATUS) begin
        o_rdata <= status_q;
      end else if (i_araddr == OFS_MASK) begin
        o_rdata <= mask_q;
      end else if (i_araddr == OFS_STATE) begin
        o_rdata <= {28'h000_0000, busy, pd_pin_s, o_power_down, o_col};
      end else begin
        o_rdata <= '0;
        o_rresp <= RESP_SLVERR;
      end
    end else if (o_rvalid && i_rready) begin
      o_rvalid  <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  // control: the pin reset puts it back to its initial value
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_q <= CTRL_RST;
    end else if (rst_req) begin
      ctrl_q <= CTRL_RST;
    end else if (axi_wr_ctrl) begin
      ctrl_q <= (ctrl_q & ~wmask) | (wdata_q & wmask & 32'h0000_00FF);
    end else if (mwr_q && mwr_idx_q == OFS_CTRL[3:2]) begin
      ctrl_q <= {16'h0000, mwr_dat_q & 16'h00FF};
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mask_q <= MASK_RST;
    end else if (rst_req) begin
      mask_q <= MASK_RST;
    end else if (axi_wr_mask) begin
      mask_q <= (mask_q & ~wmask) | (wdata_q & wmask & 32'(2**EV_W - 1));
    end else if (mwr_q && mwr_idx_q == OFS_MASK[3:2]) begin
      mask_q <= {16'h0000, mwr_dat_q & 16'(2**EV_W - 1)};
    end
  end

  // sticky events: a new event wins over a same-cycle clear
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      status_q <= STATUS_RST;
    end else if (rst_req) begin
      status_q <= STATUS_RST;
    end else begin
      status_q <= (status_q
                   & ~(axi_wr_stat ? (wdata_q & wmask) : 32'h0000_0000)
                   & ~((mwr_q && mwr_idx_q == OFS_STATUS[3:2]) ? {16'h0000, mwr_dat_q}
                                                                : 32'h0000_0000))
                  | {{(32-EV_W){1'b0}}, ev};
    end
  end

  // collision and power-down
  always_comb begin
    col_d = 1'b0;
    if (!ctrl_q.full_duplex && !ctrl_q.rmii_mode) begin
      col_d = i_tx_active && i_rx_active;
    end
    pd_d = !ctrl_q.irq_pin_sel && !pd_pin_s;
  end

  assign ev[EV_COL]  = col_d && !o_col;
  assign ev[EV_PD]   = pd_d && !o_power_down;
  assign ev[EV_MDIO] = m_done_q;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_col        <= 1'b0;
      o_power_down <= 1'b0;
      o_core_rst   <= 1'b0;
    end else begin
      o_col        <= col_d && !rst_req;
      o_power_down <= pd_d && !rst_req;
      o_core_rst   <= rst_req;
    end
  end

  // interrupt output and open-drain shared pin
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_irq                  <= 1'b0;
      o_irq_or_powerdown_pin <= 1'b0;
      o_irq_or_powerdown_oe  <= 1'b0;
    end else begin
      o_irq                  <= |(status_q & mask_q);
      o_irq_or_powerdown_pin <= 1'b0;
      o_irq_or_powerdown_oe  <= ctrl_q.irq_pin_sel && |(status_q & mask_q);
    end
  end

  // management engine: the pin clock is only sampled, so no lower rate limit exists
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mdc_prev_q <= 1'b0;
    end else begin
      mdc_prev_q <= mdc_s;
    end
  end

  assign mdc_rise = mdc_s && !mdc_prev_q;
  assign hdr_d    = {hdr_q[10:0], mdio_s};
  assign busy     = (ms_q != MS_PRE);

  always_comb begin
    mrd_val = 16'h0000;
    if (hdr_q[4:2] == 3'h0) begin
      case (hdr_q[1:0])
        OFS_CTRL[3:2]:   mrd_val = ctrl_q[15:0];
        OFS_STATUS[3:2]: mrd_val = status_q[15:0];
        OFS_MASK[3:2]:   mrd_val = mask_q[15:0];
        default:         mrd_val = {12'h000, busy, pd_pin_s, o_power_down, o_col};
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ms_q      <= MS_PRE;
      mcnt_q    <= '0;
      hdr_q     <= '0;
      mdat_q    <= '0;
      mrd_q     <= 1'b0;
      o_mdio    <= 1'b0;
      o_mdio_oe <= 1'b0;
    end else if (rst_req) begin
      ms_q      <= MS_PRE;
      mcnt_q    <= '0;
      o_mdio_oe <= 1'b0;
    end else if (mdc_rise) begin
      case (ms_q)
        MS_PRE: begin
          o_mdio_oe <= 1'b0;
          if (mdio_s) begin
            if (mcnt_q != PRE_LEN) begin
              mcnt_q <= mcnt_q + 1'b1;
            end
          end else begin
            if (mcnt_q == PRE_LEN) begin
              ms_q <= MS_ST;
            end
            mcnt_q <= '0;
          end
        end
        MS_ST: begin
          mcnt_q <= '0;
          ms_q   <= mdio_s ? MS_HDR : MS_PRE;
        end
        MS_HDR: begin
          hdr_q  <= hdr_d;
          mcnt_q <= mcnt_q + 1'b1;
          if (mcnt_q[3:0] == HDR_LAST) begin
            mcnt_q <= '0;
            mrd_q  <= (hdr_d[11:10] == OP_RD);
            if (hdr_d[9:5] == ctrl_q.phy_addr
                && (hdr_d[11:10] == OP_RD || hdr_d[11:10] == OP_WR)) begin
              ms_q <= MS_TA;
            end else begin
              ms_q <= MS_PRE;
            end
          end
        end
        MS_TA: begin
          mcnt_q <= mcnt_q + 1'b1;
          if (mcnt_q == 6'h00) begin
            // first turnaround bit released, second one driven low on reads
            o_mdio    <= 1'b0;
            o_mdio_oe <= mrd_q;
            mdat_q    <= mrd_val;
          end else begin
            mcnt_q <= '0;
            ms_q   <= MS_DATA;
            if (mrd_q) begin
              o_mdio <= mdat_q[15];
              mdat_q <= {mdat_q[14:0], 1'b0};
            end
          end
        end
        MS_DATA: begin
          mcnt_q <= mcnt_q + 1'b1;
          if (mrd_q) begin
            o_mdio <= mdat_q[15];
            mdat_q <= {mdat_q[14:0], 1'b0};
          end else begin
            mdat_q <= {mdat_q[14:0], mdio_s};
          end
          if (mcnt_q[3:0] == DAT_LAST) begin
            o_mdio_oe <= 1'b0;
            mcnt_q    <= '0;
            ms_q      <= MS_PRE;
          end
        end
        default: begin
          ms_q      <= MS_PRE;
          o_mdio_oe <= 1'b0;
        end
      endcase
    end
  end

  // write strobe and frame-done event, one cycle each
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mwr_q     <= 1'b0;
      mwr_idx_q <= '0;
      mwr_dat_q <= '0;
      m_done_q  <= 1'b0;
    end else begin
      mwr_q    <= 1'b0;
      m_done_q <= 1'b0;
      if (!rst_req && mdc_rise && ms_q == MS_DATA && mcnt_q[3:0] == DAT_LAST) begin
        m_done_q  <= 1'b1;
        mwr_q     <= !mrd_q && (hdr_q[4:2] == 3'h0);
        mwr_idx_q <= hdr_q[1:0];
        mwr_dat_q <= {mdat_q[14:0], mdio_s};
      end
    end
  end

endmodule

// ---- phy_mgmt_pkg.sv ----
// constants, field layouts and types shared by the management control-pin block
// assumes a single 20 MHz system clock; all pins arrive asynchronously
package phy_mgmt_pkg;

  localparam int unsigned CLK_HZ      = 20_000_000;
  localparam int unsigned RST_MIN_NS  = 10_000;
  localparam int unsigned RST_MIN_CYC = (RST_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned RST_CNT_W   = 8;

  // register byte offsets
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_MASK   = 4'h8;
  localparam logic [3:0] OFS_STATE  = 4'hC;

  // event bits, shared by status and mask
  localparam int unsigned EV_COL  = 0;
  localparam int unsigned EV_PD   = 1;
  localparam int unsigned EV_MDIO = 2;
  localparam int unsigned EV_W    = 3;

  localparam logic [31:0] CTRL_RST   = 32'h0000_0008;
  localparam logic [31:0] STATUS_RST = 32'h0000_0000;
  localparam logic [31:0] MASK_RST   = 32'h0000_0000;

  // management frame
  localparam logic [5:0] PRE_LEN  = 6'h20;
  localparam logic [3:0] HDR_LAST = 4'hB;
  localparam logic [3:0] DAT_LAST = 4'hF;
  localparam logic [1:0] OP_RD    = 2'h2;
  localparam logic [1:0] OP_WR    = 2'h1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [23:0] rsvd;
    logic [4:0]  phy_addr;
    logic        rmii_mode;
    logic        full_duplex;
    logic        irq_pin_sel;
  } ctrl_t;

  typedef enum logic [2:0] {
    MS_PRE  = 3'h0,
    MS_ST   = 3'h1,
    MS_HDR  = 3'h3,
    MS_TA   = 3'h2,
    MS_DATA = 3'h6
  } mdio_state_t;

endpackage

// ---- phy_sync2.sv ----
// two-stage synchroniser for asynchronous pin levels
// assumes the inputs are levels held longer than two clock periods
`timescale 1ns/1ps
module phy_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clk,   // system clock
  input  wire logic         i_nrst,  // async reset, active low
  input  wire logic [W-1:0] i_async, // asynchronous levels
  output logic      [W-1:0] o_sync   // synchronised levels
);

  logic [W-1:0] meta_q;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule

// ---- phy_rst_filter.sv ----
// reset pin pulse filter: raises a reset request once the pin stayed low long enough
// assumes its input is already synchronised to i_clk
`timescale 1ns/1ps
module phy_rst_filter
  import phy_mgmt_pkg::*;
(
  input  wire logic i_clk,      // system clock
  input  wire logic i_nrst,     // async reset, active low
  input  wire logic i_pin_n,    // synchronised reset pin, active low
  output logic      o_rst_req   // reset request, level
);

  logic [RST_CNT_W-1:0] cnt_q;

  // short glitches never reach the count, so they cannot reset the core
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_q <= '0;
    end else if (i_pin_n) begin
      cnt_q <= '0;
    end else if (cnt_q != RST_CNT_W'(RST_MIN_CYC)) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // request stands from the count onward until the pin rises again
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rst_req <= 1'b0;
    end else begin
      o_rst_req <= !i_pin_n && (cnt_q == RST_CNT_W'(RST_MIN_CYC - 1));
      if (!i_pin_n && o_rst_req) begin
        o_rst_req <= 1'b1;
      end
    end
  end

endmodule

// ---- phy_mgmt_ctrl_monitor.sv ----
// assertion checker for the management control-pin block, bound to its top module
// assumes management clock half periods of several system clocks
`timescale 1ns/1ps
module phy_mgmt_ctrl_monitor (
  input wire logic i_clk,                  // clock
  input wire logic i_nrst,                 // reset, active low
  input wire logic o_bvalid,               // write response valid
  input wire logic i_bready,               // write response ready
  input wire logic o_rvalid,               // read data valid
  input wire logic i_rready,               // read data ready
  input wire logic i_tx_active,            // transmit active
  input wire logic i_rx_active,            // receive active
  input wire logic o_col,                  // collision
  input wire logic i_mdc,                  // management clock
  input wire logic o_mdio_oe,              // data line drive
  input wire logic i_irq_or_powerdown_pin, // shared pin level
  input wire logic o_irq_or_powerdown_pin, // shared pin out value
  input wire logic o_irq_or_powerdown_oe,  // shared pin sink
  input wire logic i_rst_pin_n,            // reset pin
  input wire logic o_core_rst,             // core reset
  input wire logic o_power_down,           // power-down
  input wire logic o_irq                   // interrupt
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  logic [8:0] low_run_q;  // raw reset-pin low run, saturating
  logic [4:0] oe_rises_q; // mdc rises while the device drives the line

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst || i_rst_pin_n) begin
      low_run_q <= 9'h000;
    end else if (low_run_q != 9'h1FF) begin
      low_run_q <= low_run_q + 9'h001;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst || !o_mdio_oe) begin
      oe_rises_q <= 5'h00;
    end else if ($rose(i_mdc) && oe_rises_q != 5'h1F) begin
      oe_rises_q <= oe_rises_q + 5'h01;
    end
  end

  col_cause_a: assert property (o_col |-> $past(i_tx_active) && $past(i_rx_active))
    else $error("collision high without both media active");
  mdio_edge_a: assert property ($changed(o_mdio_oe) |-> $past(i_mdc))
    else $error("data drive changed away from a clock rise");
  mdio_release_a: assert property (oe_rises_q <= 5'h11)
    else $error("data line held past the last data bit");
  pd_entry_a: assert property ($rose(o_power_down) |-> !$past(i_irq_or_powerdown_pin, 2))
    else $error("power-down entered without a low pin");
  irq_sink_a: assert property (o_irq_or_powerdown_oe |-> o_irq || $past(o_irq))
    else $error("shared pin sunk with no interrupt pending");
  pin_no_high_a: assert property (!o_irq_or_powerdown_pin)
    else $error("shared pin out value not low");
  rst_filter_a: assert property ($rose(o_core_rst) |-> low_run_q >= 9'h0C8)
    else $error("core reset from a short pin pulse");
  rst_long_a: assert property (low_run_q == 9'h0D2 |-> o_core_rst)
    else $error("long pin pulse gave no core reset");
  rst_clear_a: assert property ($rose(o_core_rst) |-> ##3 !o_irq && !o_irq_or_powerdown_oe)
    else $error("interrupt survived a core reset");
  bresp_hold_a: assert property ($fell(o_bvalid) |-> $past(i_bready))
    else $error("write response dropped before ready");
  rdata_hold_a: assert property ($fell(o_rvalid) |-> $past(i_rready))
    else $error("read data dropped before ready");

  cover property ($rose(o_col));
  cover property ($rose(o_mdio_oe));
  cover property ($rose(o_core_rst));
  cover property ($rose(o_irq_or_powerdown_oe));
endmodule

bind phy_mgmt_ctrl phy_mgmt_ctrl_monitor u_phy_mgmt_ctrl_monitor (
  .i_clk, .i_nrst, .o_bvalid, .i_bready, .o_rvalid, .i_rready, .i_tx_active, .i_rx_active,
  .o_col, .i_mdc, .o_mdio_oe, .i_irq_or_powerdown_pin, .o_irq_or_powerdown_pin,
  .o_irq_or_powerdown_oe, .i_rst_pin_n, .o_core_rst, .o_power_down, .o_irq
);

// ---- mgmt_station.sv ----
// management station model: makes the serial clock and drives the data line in frames
// assumes the bench resolves the data line with a pull-up
`timescale 1ns/1ps
module mgmt_station
  import phy_mgmt_pkg::*;
(
  input  wire logic i_line, // resolved data line
  output logic      o_mdc,  // management clock, low between frames
  output logic      o_dat,  // data value driven
  output logic      o_oe    // high while driving
);
  int half = 200; // ns; 400 ns period keeps to 2.5 MHz

  initial begin
    o_mdc = 1'b0;
    o_dat = 1'b1;
    o_oe  = 1'b0;
  end

  // data moves while the clock is low, sampled at the rise
  task automatic cyc(input logic b, output logic s);
    o_dat = b;
    #(half);
    o_mdc = 1'b1;
    s = i_line;
    #(half);
    o_mdc = 1'b0;
  endtask

  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] f;
    logic        s;
    f = {32'hFFFF_FFFF, 2'b01, op, pa, ra, 2'b10, wd};
    rd = 16'h0000;
    #13; // keep clock edges off the system clock's phase
    o_oe = 1'b1;
    for (int i = 63; i >= 0; i--) begin
      if (i == 17 && op == OP_RD) o_oe = 1'b0; // hand over at turnaround
      cyc(f[i], s);
      if (i < 16) rd[i] = s;
    end
    o_oe = 1'b0;
  endtask
endmodule

// ---- phy_mgmt_ctrl_tb.sv ----
// self-checking bench: register access, collision, shared pin, management frames, pin reset
// assumes package, design, checker and station model compiled before it
`timescale 1ns/1ps
module phy_mgmt_ctrl_tb;
  import phy_mgmt_pkg::*;

  logic        i_clk = 1'b0, i_nrst = 1'b0, i_rst_pin_n = 1'b1, pd_drv_n = 1'b1;
  logic [3:0]  i_awaddr = 4'h0, i_araddr = 4'h0, i_wstrb = 4'hF;
  logic [31:0] i_wdata = 32'h0000_0000, rdat, rnd;
  logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
  logic        i_arvalid = 1'b0, i_rready = 1'b0, i_tx_active = 1'b0, i_rx_active = 1'b0;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_col, o_mdio, o_mdio_oe;
  logic        o_irq_or_powerdown_pin, o_irq_or_powerdown_oe, o_core_rst, o_power_down, o_irq;
  logic [1:0]  o_bresp, o_rresp, rrsp;
  logic [31:0] o_rdata;
  logic [15:0] rd16;
  wire logic   i_mdc, i_mdio, i_irq_or_powerdown_pin, sta_dat, sta_oe;
  int          miscompares = 0, samples_checked = 0, cycles = 0, col_seen = 0, mask_m;
  integer      seed = 32'h5104;

  // both lines have pull-ups, so a released line reads high
  assign i_mdio = o_mdio_oe ? o_mdio : (sta_oe ? sta_dat : 1'b1);
  assign i_irq_or_powerdown_pin = o_irq_or_powerdown_oe ? o_irq_or_powerdown_pin : pd_drv_n;

  phy_mgmt_ctrl u_phy_mgmt_ctrl (
    .i_clk, .i_nrst, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid,
    .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata,
    .o_rresp, .o_rvalid, .i_rready, .i_tx_active, .i_rx_active, .o_col, .i_mdc, .i_mdio,
    .o_mdio, .o_mdio_oe, .i_irq_or_powerdown_pin, .o_irq_or_powerdown_pin,
    .o_irq_or_powerdown_oe, .i_rst_pin_n, .o_core_rst, .o_power_down, .o_irq
  );
  mgmt_station u_mgmt_station (.i_line(i_mdio), .o_mdc(i_mdc), .o_dat(sta_dat), .o_oe(sta_oe));

  always #25 i_clk = ~i_clk;

  task automatic conclude();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge i_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    while (!done) begin
      @(posedge i_clk);
      if (i_awvalid && o_awready) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready) i_wvalid <= 1'b0;
      if (o_bvalid) begin
        r = o_bresp;
        i_bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge i_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    while (!done) begin
      @(posedge i_clk);
      if (i_arvalid && o_arready) i_arvalid <= 1'b0;
      if (o_rvalid) begin
        d = o_rdata;
        r = o_rresp;
        i_rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic wchk(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    axi_wr(a, d, rrsp);
    chk(rrsp, er);
  endtask

  task automatic rchk(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    axi_rd(a, rdat, rrsp);
    chk(rdat, ed);
    chk(rrsp, er);
  endtask

  initial begin
    repeat (3) @(posedge i_clk);
    i_nrst <= 1'b1;
    rchk(OFS_CTRL, 32'h0000_0008, RESP_OKAY);
    rchk(OFS_STATUS, 32'h0000_0000, RESP_OKAY);
    rchk(OFS_MASK, 32'h0000_0000, RESP_OKAY);
    rchk(OFS_STATE, 32'h0000_0004, RESP_OKAY);
    rchk(4'h2, 32'h0000_0000, RESP_SLVERR);
    wchk(4'h6, 32'h0000_0007, RESP_SLVERR);
    // every duplex and interface mode against random media activity
    for (int m = 0; m < 4; m++) begin
      wchk(OFS_CTRL, 32'h0000_0008 | (m << 1), RESP_OKAY);
      repeat (40) begin
        @(posedge i_clk);
        rnd = $random(seed);
        i_tx_active <= rnd[0];
        i_rx_active <= rnd[1];
        if (m == 0 && rnd[0] && rnd[1]) col_seen = 1;
        @(posedge i_clk);
        #1 chk(o_col, (m == 0) && i_tx_active && i_rx_active);
      end
    end
    i_tx_active <= 1'b0;
    i_rx_active <= 1'b0;
    rchk(OFS_STATUS, col_seen, RESP_OKAY);
    chk(o_irq, 0);
    wchk(OFS_MASK, 32'h0000_0001, RESP_OKAY);
    repeat (3) @(posedge i_clk);
    chk(o_irq, col_seen);
    chk(o_irq_or_powerdown_oe, 0);
    wchk(OFS_STATUS, 32'h0000_0001, RESP_OKAY);
    rchk(OFS_STATUS, 32'h0000_0000, RESP_OKAY);
    chk(o_irq, 0);
    // default pin function: external low means power-down
    @(posedge i_clk);
    pd_drv_n <= 1'b0;
    repeat (6) @(posedge i_clk);
    #1 chk(o_power_down, 1);
    rchk(OFS_STATUS, 32'h0000_0002, RESP_OKAY);
    rchk(OFS_STATE, 32'h0000_0002, RESP_OKAY);
    pd_drv_n <= 1'b1;
    repeat (6) @(posedge i_clk);
    #1 chk(o_power_down, 0);
    wchk(OFS_STATUS, 32'h0000_0002, RESP_OKAY);
    // interrupt function: own sink must not power down
    wchk(OFS_CTRL, 32'h0000_0009, RESP_OKAY);
    @(posedge i_clk);
    i_tx_active <= 1'b1;
    i_rx_active <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_tx_active <= 1'b0;
    i_rx_active <= 1'b0;
    repeat (4) @(posedge i_clk);
    #1 chk(o_irq_or_powerdown_oe, 1);
    chk(o_irq_or_powerdown_pin, 0);
    chk(o_power_down, 0);
    wchk(OFS_STATUS, 32'h0000_0001, RESP_OKAY);
    repeat (3) @(posedge i_clk);
    chk(o_irq_or_powerdown_oe, 0);
    // management frames
    u_mgmt_station.frame(OP_RD, 5'h01, 5'h00, 16'h0000, rd16);
    chk(rd16, 16'h0009);
    rnd = $random(seed);
    u_mgmt_station.frame(OP_WR, 5'h01, 5'h02, rnd[15:0], rd16);
    mask_m = rnd[2:0];
    rchk(OFS_MASK, mask_m, RESP_OKAY);
    axi_rd(OFS_STATUS, rdat, rrsp);
    chk(rdat & 32'h0000_0004, 32'h0000_0004);
    u_mgmt_station.frame(OP_RD, 5'h02, 5'h00, 16'h0000, rd16);
    chk(rd16, 16'hFFFF);
    u_mgmt_station.half = 3000;
    u_mgmt_station.frame(OP_RD, 5'h01, 5'h02, 16'h0000, rd16);
    chk(rd16, mask_m);
    u_mgmt_station.half = 200;
    // reset pin: short pulse ignored, long pulse reloads
    wchk(OFS_CTRL, 32'h0000_000F, RESP_OKAY);
    @(posedge i_clk);
    i_rst_pin_n <= 1'b0;
    repeat (150) @(posedge i_clk);
    i_rst_pin_n <= 1'b1;
    repeat (10) @(posedge i_clk);
    rchk(OFS_CTRL, 32'h0000_000F, RESP_OKAY);
    @(posedge i_clk);
    i_rst_pin_n <= 1'b0;
    repeat (220) @(posedge i_clk);
    #1 chk(o_core_rst, 1);
    @(posedge i_clk);
    i_rst_pin_n <= 1'b1;
    repeat (10) @(posedge i_clk);
    rchk(OFS_CTRL, 32'h0000_0008, RESP_OKAY);
    rchk(OFS_MASK, 32'h0000_0000, RESP_OKAY);
    rchk(OFS_STATUS, 32'h0000_0000, RESP_OKAY);
    conclude();
  end
endmodule
